// ### adc_pkg.sv
package adc_pkg;

	// System clock
	localparam int CLK_HZ = 20_000_000;

	// Conversion frame shape
	localparam int RES_BITS     = 10;
	localparam int SUB_BITS     = 2;
	localparam int DATA_BITS    = RES_BITS + SUB_BITS;
	localparam int LEAD_ZEROS   = 3;
	localparam int MSB_EDGE     = 3;
	localparam int FRAME_EDGES  = LEAD_ZEROS + DATA_BITS;
	localparam int CODE_STEPS   = 1024;
	localparam int EDGE_W       = 4;
	localparam int FIFO_DEPTH   = 16;

	// Edge counts as seen before the edge that carries a bit (device), and after it for the host shift window
	localparam logic [EDGE_W-1:0] FIRST_BIT_CNT = 4'(MSB_EDGE - 1);
	localparam logic [EDGE_W-1:0] LSB_BIT_CNT   = 4'(MSB_EDGE + RES_BITS - 2);
	localparam logic [EDGE_W-1:0] FRAME_CNT     = 4'(FRAME_EDGES);
	localparam logic [EDGE_W-1:0] SHIFT_LO_CNT  = 4'(MSB_EDGE);
	localparam logic [EDGE_W-1:0] SHIFT_HI_CNT  = 4'(MSB_EDGE + DATA_BITS - 1);

	// Link timing, figures as printed
	localparam int SCLK_MAX_HZ         = 4_800_000;
	localparam int ACQUIRE_TIME_NS     = 625;
	localparam int SELECT_HIGH_TIME_NS = 100;
	localparam int SETUP_TIME_NS       = 45;
	localparam int WAKE_TIME_US        = 1400;

	// Least time in ns to whole clock cycles, never below one
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SCLK_HALF_CYC    = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
	localparam int ACQUIRE_CYC      = ns_to_cycles(ACQUIRE_TIME_NS);
	localparam int SELECT_HIGH_CYC  = ns_to_cycles(SELECT_HIGH_TIME_NS);
	localparam int SETUP_CYC        = ns_to_cycles(SETUP_TIME_NS);
	localparam int GAP_CYC          = (ACQUIRE_CYC > SELECT_HIGH_CYC) ? ACQUIRE_CYC
	                                                                  : SELECT_HIGH_CYC;
	localparam int WAKE_CYC         = WAKE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int WAIT_W           = 16;

endpackage

// ### adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
	logic sclk;
	logic cs_n;
	logic shutdown_n;
	logic dout_o;
	logic dout_oe;
	logic dout;

	// Undriven line idles high through the pull-up
	assign dout = dout_oe ? dout_o : 1'b1;

	modport device (
		input  sclk,
		input  cs_n,
		input  shutdown_n,
		output dout_o,
		output dout_oe
	);

	modport host (
		output sclk,
		output cs_n,
		output shutdown_n,
		input  dout
	);
endinterface

// ### adc_device.sv
`timescale 1ns/1ps
// What this block and its host do
// [R1] Shutdown low stops all converter activity
// [R2] Shutdown high restores normal conversion operation
// [R3] Select high puts data output high-impedance
// [R4] Select fall holds sample, starts conversion, drives low
// [R5] Output changes only on serial clock rise
// [R6] Serial clock steps approximation, bit shifted immediately
// [R7] MSB on third rising edge, then descending
// [R8] Three zeros plus twelve bits: fifteen edges
// [R9] Extra clocks give zeros, converter undisturbed
// [R10] Host raises select after LSB, waits high time
// [R11] Result is straight binary, step reference/1024
// [R12] Conversion end returns track/hold to tracking
// [R13] Host allows acquisition time before next start
// [R14] Host waits reference settling after power-up
// [R15] Host waits wake time after shutdown release
// [R16] Internal reference disabled during shutdown
// [R17] Host limits serial clock frequency
// [R18] After aborted conversion host waits acquisition time
// [R19] Select rise abandons conversion, resets sequencer
module adc_device #(
	parameter int RES = adc_pkg::RES_BITS
) (
	// System clock domain
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire logic           ce,
	// Link
	adc_link_if.device          link,
	// Quantised analog input, straight binary of reference/1024 steps
	input  wire logic [RES-1:0] analog_in,
	// Status towards the user
	output logic                reference_on,
	output logic                tracking,
	output logic                result_strobe,
	output logic [RES-1:0]      result
);

	// Link domain state
	logic [adc_pkg::EDGE_W-1:0] edge_reg;
	logic [adc_pkg::EDGE_W-1:0] edge_next;
	logic [RES-1:0]             approx_register_reg;
	logic [RES-1:0]             approx_register_next;
	logic                       dout_reg;
	logic                       dout_next;
	logic                       done_reg;
	logic                       done_next;
	logic                       enable_reg;

	// System domain state
	logic                       shutdown_n_meta_reg;
	logic                       shutdown_n_sync_reg;
	logic                       cs_meta_reg;
	logic                       cs_sync_reg;
	logic                       done_meta_reg;
	logic                       done_sync_reg;
	logic                       done_seen_reg;
	logic [RES-1:0]             held_reg;
	logic                       reference_on_reg;
	logic                       tracking_reg;
	logic                       result_strobe_reg;
	logic [RES-1:0]             result_reg;

	// Sequencer decode
	wire                        in_result;
	wire [adc_pkg::EDGE_W-1:0]  bit_idx;
	wire [RES-1:0]              trial;
	wire                        keep;
	wire                        at_lsb;
	wire                        frame_full;
	wire                        track_next;
	wire                        done_rise;
	wire                        seq_clear;

	// Edge about to happen is edge_reg + 1
	assign in_result  = (edge_reg >= adc_pkg::FIRST_BIT_CNT)
	                  && (edge_reg <= adc_pkg::LSB_BIT_CNT);
	assign bit_idx    = adc_pkg::LSB_BIT_CNT - edge_reg;
	assign trial      = approx_register_reg | (RES'(1) << bit_idx); // see [R11]
	assign keep       = held_reg >= trial;
	assign at_lsb     = edge_reg == adc_pkg::LSB_BIT_CNT;
	assign frame_full = edge_reg == adc_pkg::FRAME_CNT;

	// One decision per edge, shifted out at once
	assign approx_register_next = (in_result && keep) ? trial : approx_register_reg; // see [R6]
	assign dout_next  = in_result && keep; // see [R7] see [R9]
	assign edge_next  = frame_full ? edge_reg : edge_reg + 4'h1;
	assign done_next  = done_reg || at_lsb;

	// Serial clock may be idle around a wake-up, so shutdown holds the sequencer clear directly
	assign seq_clear = link.cs_n || !link.shutdown_n; // see [R1] see [R2]

	// Select high or shutdown clears the sequencer at once
	always_ff @(posedge link.sclk or posedge seq_clear) begin
		if (seq_clear) begin // see [R19]
			edge_reg            <= '0;
			approx_register_reg <= '0;
			dout_reg            <= 1'b0;
			done_reg            <= 1'b0;
		end else begin
			edge_reg            <= edge_next;
			approx_register_reg <= approx_register_next;
			dout_reg            <= dout_next; // see [R5]
			done_reg            <= done_next;
		end
	end

	// Output enable: set by select fall, cleared by select rise
	always_ff @(negedge link.cs_n or posedge link.cs_n) begin
		if (link.cs_n) begin
			enable_reg <= 1'b0; // see [R3]
		end else begin
			enable_reg <= 1'b1; // see [R4]
		end
	end

	assign link.dout_o  = dout_reg;
	assign link.dout_oe = enable_reg;

	// System domain synchronisers
	always_ff @(posedge clk) begin
		if (reset) begin
			shutdown_n_meta_reg <= 1'b0;
			shutdown_n_sync_reg <= 1'b0;
			cs_meta_reg   <= 1'b1;
			cs_sync_reg   <= 1'b1;
			done_meta_reg <= 1'b0;
			done_sync_reg <= 1'b0;
		end else if (ce) begin
			shutdown_n_meta_reg <= link.shutdown_n;
			shutdown_n_sync_reg <= shutdown_n_meta_reg;
			cs_meta_reg   <= link.cs_n;
			cs_sync_reg   <= cs_meta_reg;
			done_meta_reg <= done_reg;
			done_sync_reg <= done_meta_reg;
		end
	end

	// Out of shutdown, track while deselected or once the result is complete
	assign track_next = shutdown_n_sync_reg && (cs_sync_reg || done_sync_reg); // see [R12]
	assign done_rise  = done_sync_reg && !done_seen_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			reference_on_reg  <= 1'b0;
			tracking_reg      <= 1'b0;
			done_seen_reg     <= 1'b0;
			result_strobe_reg <= 1'b0;
			result_reg        <= '0;
			held_reg          <= '0;
		end else if (ce) begin
			reference_on_reg  <= shutdown_n_sync_reg; // see [R16]
			tracking_reg      <= track_next;
			done_seen_reg     <= done_sync_reg;
			result_strobe_reg <= done_rise;
			if (done_rise) begin
				result_reg <= approx_register_reg;
			end
			// Held value stays frozen while a conversion runs
			if (track_next) begin // see [R4]
				held_reg <= analog_in;
			end
		end
	end

	assign reference_on  = reference_on_reg;
	assign tracking      = tracking_reg;
	assign result_strobe = result_strobe_reg;
	assign result        = result_reg;

endmodule

// ### adc_host.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = adc_pkg::RES_BITS,
	parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      count_reg;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = mem[rd_reg];

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
		end else if (ce) begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module adc_host #(
	parameter int WAKE_CYC = adc_pkg::WAKE_CYC,
	parameter int DEPTH    = adc_pkg::FIFO_DEPTH
) (
	// System clock domain
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          ce,
	// Control
	input  wire logic                          run,
	input  wire logic                          sleep,
	// Link
	adc_link_if.host                           link,
	// Results
	output logic                               out_valid,
	input  wire logic                          out_ready,
	output logic [adc_pkg::RES_BITS-1:0]       out_data
);
	typedef enum logic [4:0] {
		ST_WAKE  = 5'h01,
		ST_IDLE  = 5'h02,
		ST_SETUP = 5'h04,
		ST_CLOCK = 5'h08,
		ST_GAP   = 5'h10
	} host_state_type;

	host_state_type                   state_reg;
	logic [adc_pkg::WAIT_W-1:0]       wait_reg;
	logic [adc_pkg::EDGE_W-1:0]       edge_reg;
	logic [adc_pkg::DATA_BITS-1:0]    shift_reg;
	logic                             sclk_reg;
	logic                             cs_n_reg;
	logic                             shutdown_n_reg;
	logic                             push_reg;
	logic                             dout_meta_reg;
	logic                             dout_sync_reg;
	logic                             in_ready;

	wire half_done  = wait_reg == adc_pkg::WAIT_W'(adc_pkg::SCLK_HALF_CYC - 1);
	wire wake_done  = wait_reg >= adc_pkg::WAIT_W'(WAKE_CYC - 1);
	wire setup_done = wait_reg >= adc_pkg::WAIT_W'(adc_pkg::SETUP_CYC);
	wire gap_done   = wait_reg >= adc_pkg::WAIT_W'(adc_pkg::GAP_CYC - 1);
	wire take_bit   = (edge_reg >= adc_pkg::SHIFT_LO_CNT) && (edge_reg <= adc_pkg::SHIFT_HI_CNT);
	wire last_edge  = edge_reg == adc_pkg::FRAME_CNT;

	always_ff @(posedge clk) begin
		if (reset) begin
			dout_meta_reg <= 1'b1;
			dout_sync_reg <= 1'b1;
		end else if (ce) begin
			dout_meta_reg <= link.dout;
			dout_sync_reg <= dout_meta_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg      <= ST_WAKE;
			wait_reg       <= '0;
			edge_reg       <= '0;
			shift_reg      <= '0;
			sclk_reg       <= 1'b0;
			cs_n_reg       <= 1'b1;
			shutdown_n_reg <= 1'b1;
			push_reg       <= 1'b0;
		end else if (ce) begin
			push_reg <= 1'b0;
			unique case (state_reg)
				ST_WAKE: begin
					wait_reg <= wait_reg + adc_pkg::WAIT_W'(1);
					if (wake_done) begin // see [R14] see [R15]
						state_reg <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					wait_reg <= '0;
					if (sleep) begin
						shutdown_n_reg <= 1'b0;
					end else if (!shutdown_n_reg) begin
						shutdown_n_reg <= 1'b1;
						state_reg      <= ST_WAKE;
					end else if (run && in_ready) begin
						cs_n_reg  <= 1'b0;
						edge_reg  <= '0;
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					wait_reg <= wait_reg + adc_pkg::WAIT_W'(1);
					if (setup_done) begin
						wait_reg  <= '0;
						state_reg <= ST_CLOCK;
					end
				end
				ST_CLOCK: begin
					wait_reg <= half_done ? '0 : wait_reg + adc_pkg::WAIT_W'(1); // see [R17]
					if (half_done && sclk_reg) begin
						sclk_reg <= 1'b0;
					end else if (half_done && last_edge) begin // see [R8]
						cs_n_reg  <= 1'b1; // see [R10]
						push_reg  <= 1'b1;
						state_reg <= ST_GAP;
					end else if (half_done) begin
						if (take_bit) begin
							shift_reg <= {shift_reg[adc_pkg::DATA_BITS-2:0], dout_sync_reg};
						end
						sclk_reg <= 1'b1;
						edge_reg <= edge_reg + 4'h1;
					end
				end
				ST_GAP: begin
					wait_reg <= wait_reg + adc_pkg::WAIT_W'(1);
					if (gap_done) begin // see [R13] see [R18]
						wait_reg  <= '0;
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign link.sclk       = sclk_reg;
	assign link.cs_n       = cs_n_reg;
	assign link.shutdown_n = shutdown_n_reg;

	sample_fifo #(
		.WIDTH (adc_pkg::RES_BITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (push_reg),
		.in_ready  (in_ready),
		.in_data   (shift_reg[adc_pkg::DATA_BITS-1:adc_pkg::SUB_BITS]),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);
endmodule

// ### adc_link_monitor.sv
`timescale 1ns/1ps
module adc_link_monitor (
	// System clock domain
	input wire logic clk,
	input wire logic reset,
	// Link signals
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic shutdown_n,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic       sclk_reg;
	logic [4:0] edge_reg;
	logic [4:0] gap_reg;
	wire        rise = sclk && !sclk_reg;

	// Edge count within a frame, select-high time saturating at 31
	always_ff @(posedge clk) begin
		sclk_reg <= sclk;
		edge_reg <= cs_n ? 5'h00 : edge_reg + 5'(rise);
		gap_reg  <= (reset || !cs_n) ? 5'h00 : gap_reg + 5'(gap_reg != 5'h1f);
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_idle_hiz: assert property (cs_n |-> !dout_oe)
		else $error("data driven while deselected");
	chk_start_low: assert property ($fell(cs_n) |-> dout_oe && !dout_o)
		else $error("data not low at frame start");
	chk_moves_on_rise: assert property ($changed(dout_o) && $past(dout_oe) && dout_oe |-> rise)
		else $error("data moved without clock rise");
	chk_lead_zeros: assert property (rise && edge_reg < 5'h2 |-> !dout_o)
		else $error("leading bit not zero");
	chk_tail_zeros: assert property (rise && edge_reg > 5'hb |-> !dout_o)
		else $error("trailing bit not zero");
	chk_full_frame: assert property ($rose(cs_n) |-> edge_reg == 5'hf)
		else $error("frame edge count wrong");
	chk_sclk_high: assert property ($rose(sclk) |-> sclk[*3])
		else $error("serial clock high too short");
	chk_gap_time: assert property ($fell(cs_n) |-> gap_reg >= 5'hd)
		else $error("select high time too short");
	chk_wake_wait: assert property ($rose(shutdown_n) |-> cs_n[*8])
		else $error("frame started during wake time");

	cover property ($rose(cs_n));
	cover property (rise && edge_reg == 5'he);
	cover property ($rose(shutdown_n));
endmodule

// ### test_serial_adc_conversion_control.sv
`timescale 1ns/1ps
module test_serial_adc_conversion_control;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        run = 1'b1;
	logic        sleep = 1'b0;
	logic        stall = 1'b0;
	logic        out_ready = 1'b0;
	logic        sclk_seen = 1'b0;
	logic [9:0]  analog_in = 10'h000;
	logic        reference_on;
	logic        tracking;
	logic        result_strobe;
	logic [9:0]  result;
	logic        out_valid;
	logic [9:0]  out_data;
	logic [14:0] frame_bits;
	logic [9:0]  code_q[$];
	logic [9:0]  dev_q[$];
	logic [9:0]  fifo_q[$];
	logic [9:0]  corner[4] = '{10'h000, 10'h3ff, 10'h200, 10'h155};
	logic [31:0] seed = 32'h000000e0;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          frames = 0;
	int          mark;

	adc_link_if adc_link_if_i ();
	adc_device adc_device_i (.clk, .reset, .ce, .link(adc_link_if_i.device), .analog_in,
		.reference_on, .tracking, .result_strobe, .result);
	adc_host #(.WAKE_CYC(20)) adc_host_i (.clk, .reset, .ce, .run, .sleep,
		.link(adc_link_if_i.host), .out_valid, .out_ready, .out_data);
	adc_link_monitor adc_link_monitor_i (.clk, .reset, .sclk(adc_link_if_i.sclk),
		.cs_n(adc_link_if_i.cs_n), .shutdown_n(adc_link_if_i.shutdown_n),
		.dout_o(adc_link_if_i.dout_o), .dout_oe(adc_link_if_i.dout_oe));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Wire image: two zeros, code MSB first, sub-bits and a trailing zero
	function automatic logic [15:0] frame_of(input logic [9:0] code);
		return {3'b000, code, 3'b000};
	endfunction

	task automatic compare_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic compare_flag(input string what, input logic exp, input logic seen);
		compare_word(what, 16'(exp), 16'(seen));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always #25 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			complete_run();
		end
	end

	// The sample is taken at the select fall
	always @(negedge adc_link_if_i.cs_n) begin
		code_q.push_back(analog_in);
		dev_q.push_back(analog_in);
		fifo_q.push_back(analog_in);
	end

	always @(posedge adc_link_if_i.cs_n) if (!reset) begin
		compare_word("frame", frame_of(code_q.pop_front()), 16'(frame_bits));
		compare_flag("tracking", 1'b1, tracking);
		frames++;
	end

	always @(negedge clk) begin
		seed = xs(seed);
		if (adc_link_if_i.sclk && !sclk_seen && !adc_link_if_i.cs_n)
			frame_bits = {frame_bits[13:0], adc_link_if_i.dout};
		sclk_seen = adc_link_if_i.sclk;
		if (adc_link_if_i.cs_n)
			analog_in = (frames < 4) ? corner[frames] : seed[25:16];
		if (!reset && result_strobe === 1'b1)
			compare_word("result", 16'(dev_q.pop_front()), 16'(result));
		out_ready = !stall && (seed[0] || seed[1]);
		if (out_valid === 1'b1 && out_ready)
			compare_word("fifo", 16'(fifo_q.pop_front()), 16'(out_data));
	end

	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		wait (frames >= 10);
		// Fill the buffer with the drain side stalled
		do @(negedge adc_link_if_i.cs_n); while (out_valid !== 1'b0);
		stall = 1'b1;
		mark = frames;
		repeat (2400) @(negedge clk);
		compare_word("stalled", 16'(adc_pkg::FIFO_DEPTH), 16'(frames - mark));
		compare_flag("full", 1'b1, out_valid);
		stall = 1'b0;
		wait (frames >= mark + 20);
		@(posedge adc_link_if_i.cs_n);
		@(negedge clk) sleep = 1'b1;
		repeat (10) @(negedge clk);
		mark = frames;
		repeat (300) @(negedge clk);
		compare_flag("reference", 1'b0, reference_on);
		compare_word("sleep", 16'(mark), 16'(frames));
		sleep = 1'b0;
		repeat (300) @(negedge clk);
		compare_flag("reference", 1'b1, reference_on);
		wait (frames >= mark + 3);
		// Stop new frames so every queue can drain before the final look
		@(negedge clk) run = 1'b0;
		repeat (60) @(negedge clk);
		compare_word("queue", 16'h0000, 16'(fifo_q.size()));
		compare_word("results", 16'h0000, 16'(dev_q.size()));
		complete_run();
	end
endmodule
